/* File: atd_decoder.sv */
// atd_decoder: task file register decoder of a parallel disk port
// assumes: host pins are asynchronous to clk and pass synchronisers;
// the core drives status, error and command results on its side ports.
// Notes on behaviour
// - float or ignore on unselected or invalid addresses
// - control block: mirror status, device control, address
// - command block maps eight registers by address
// - lba from sector, cylinders and head field
// - host selects then strobes; data routed accordingly
// - mirrored status bit order bsy down to err
// - mirrored status equals current status exactly
// - mirrored status read leaves interrupt pending
// - check power mode in idle returns ffh
// - command write starts execution immediately
// - srst holds device in reset, 5 ms minimum; here srst is a plain level and the hold is left to the host
// - interrupt enabled only with nien low and selected
`timescale 1ns/10ps
`default_nettype none
module atd_decoder #(
    parameter logic DEV_NUM = 1'b0
) (
    // clock and control
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // host pins, active low strobes and selects
    input  wire logic        cs0_n,
    input  wire logic        cs1_n,
    input  wire logic [2:0]  da,
    input  wire logic        dior_n,
    input  wire logic        diow_n,
    input  wire logic [15:0] dd_in,
    output logic      [15:0] dd_out,
    output logic             dd_oe_n,
    output logic             intrq,
    // core side
    input  wire logic [7:0]  core_status,
    input  wire logic [7:0]  core_error,
    input  wire logic        core_irq_set,
    input  wire logic        core_cpm_done,
    input  wire logic        core_idle,
    input  wire logic [15:0] core_rd_data,
    output logic      [7:0]  cmd_code,
    output logic             cmd_start,
    output logic      [7:0]  features,
    output logic      [27:0] lba_addr,
    output logic             lba_mode,
    output logic             dev_srst,
    output logic             data_wr,
    output logic             data_rd,
    output logic      [15:0] data_wr_word
);
    ////////////////////////////////////////////////////////////////////////
    logic cs0_s, cs1_s, rd_s, wr_s;
    logic [2:0] da_s;
    logic rd_d1_q, wr_d1_q;

    atd_sync #(.RST_VAL(1'b1)) u_cs0 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(cs0_n), .sync_q(cs0_s));
    atd_sync #(.RST_VAL(1'b1)) u_cs1 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(cs1_n), .sync_q(cs1_s));
    atd_sync #(.RST_VAL(1'b1)) u_rd  (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(dior_n), .sync_q(rd_s));
    atd_sync #(.RST_VAL(1'b1)) u_wr  (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(diow_n), .sync_q(wr_s));
    atd_sync #(.RST_VAL(1'b0)) u_da0 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(da[0]), .sync_q(da_s[0]));
    atd_sync #(.RST_VAL(1'b0)) u_da1 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(da[1]), .sync_q(da_s[1]));
    atd_sync #(.RST_VAL(1'b0)) u_da2 (.clk(clk), .sys_rst(sys_rst), .ce(ce), .pin(da[2]), .sync_q(da_s[2]));

    // write data is sampled at the strobe's trailing edge, while the host still holds it stable
    logic [15:0] dd_s1_q, dd_s_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dd_s1_q <= atd_pkg::RST_WORD;
            dd_s_q  <= atd_pkg::RST_WORD;
            rd_d1_q <= 1'b1;
            wr_d1_q <= 1'b1;
        end else if (ce) begin
            dd_s1_q <= dd_in;
            dd_s_q  <= dd_s1_q;
            rd_d1_q <= rd_s;
            wr_d1_q <= wr_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // block select decode
    logic cmd_sel, ctl_sel, rd_act, rd_fall, wr_rise, data_hit;

    assign cmd_sel = !cs0_s && cs1_s;
    assign ctl_sel = cs0_s && !cs1_s && da_s[2] && da_s[1];
    assign rd_act  = !rd_s && (cmd_sel || ctl_sel);
    assign rd_fall = rd_d1_q && !rd_s;
    // writes commit on the trailing edge, after the data has settled
    assign wr_rise = !wr_d1_q && wr_s;
    // data writes share the soft reset gate of the other command block registers
    assign data_hit = wr_rise && cmd_sel && !dev_srst && (da_s == atd_pkg::ADR_DATA);

    ////////////////////////////////////////////////////////////////////////
    // task file registers
    logic [7:0] seccnt_q, secnum_q, cyllo_q, cylhi_q, devhead_q, ctl_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            features <= atd_pkg::RST_BYTE;
            seccnt_q <= atd_pkg::RST_BYTE;
            secnum_q <= atd_pkg::RST_BYTE;
            cyllo_q <= atd_pkg::RST_BYTE;
            cylhi_q <= atd_pkg::RST_BYTE;
            devhead_q <= atd_pkg::RST_DEVHEAD;
            cmd_code <= atd_pkg::RST_BYTE;
        end else if (ce) begin
            if (core_cpm_done && core_idle) begin
                seccnt_q <= atd_pkg::CPM_IDLE_VAL;
            end
            if (wr_rise && cmd_sel && !dev_srst) begin
                unique case (da_s)
                    atd_pkg::ADR_DATA:     ;
                    atd_pkg::ADR_ERR_FEAT: features <= dd_s_q[7:0];
                    atd_pkg::ADR_SECCNT:   seccnt_q <= dd_s_q[7:0];
                    atd_pkg::ADR_SECNUM:   secnum_q <= dd_s_q[7:0];
                    atd_pkg::ADR_CYLLO:    cyllo_q <= dd_s_q[7:0];
                    atd_pkg::ADR_CYLHI:    cylhi_q <= dd_s_q[7:0];
                    atd_pkg::ADR_DEVHEAD:  devhead_q <= dd_s_q[7:0];
                    atd_pkg::ADR_STATCMD:  cmd_code <= dd_s_q[7:0];
                endcase
            end
        end
    end

    // device control lives outside the soft reset so srst can be released
    // the address register at 111 takes no writes, so only 110 lands here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_q <= atd_pkg::RST_CTL;
        end else if (ce && wr_rise && ctl_sel && (da_s == atd_pkg::ADR_MIRROR)) begin
            ctl_q <= dd_s_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command start, data port strobes, lba and soft reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_start <= 1'b0;
            data_wr <= 1'b0;
            data_rd <= 1'b0;
            data_wr_word <= atd_pkg::RST_WORD;
            lba_addr <= 28'h0000000;
            lba_mode <= 1'b0;
            dev_srst <= 1'b0;
        end else if (ce) begin
            cmd_start <= wr_rise && cmd_sel && !dev_srst && (da_s == atd_pkg::ADR_STATCMD);
            data_wr <= data_hit;
            data_rd <= rd_fall && cmd_sel && (da_s == atd_pkg::ADR_DATA);
            // the word stays put between writes so the core may take it late
            if (data_hit) begin
                data_wr_word <= dd_s_q;
            end
            lba_addr <= {devhead_q[3:0], cylhi_q, cyllo_q, secnum_q};
            lba_mode <= devhead_q[atd_pkg::DH_LBA_BIT];
            // limitation: the 5 ms hold is the host's duty; here srst is a plain level
            dev_srst <= ctl_q[atd_pkg::CTL_SRST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pending and its gated pin
    logic irq_pend_q, dev_selected, stat_rd;

    assign dev_selected = (devhead_q[atd_pkg::DH_DRV_BIT] == DEV_NUM);
    assign stat_rd = rd_fall && cmd_sel && (da_s == atd_pkg::ADR_STATCMD);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_pend_q <= 1'b0;
            intrq <= 1'b0;
        end else if (ce) begin
            // set wins over a clear in the same cycle; the mirror read never clears
            if (core_irq_set) begin
                irq_pend_q <= 1'b1;
            end else if (stat_rd || dev_srst) begin
                irq_pend_q <= 1'b0;
            end
            intrq <= irq_pend_q && dev_selected && !ctl_q[atd_pkg::CTL_NIEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd_byte, devaddr;
    logic [15:0] rd_word;

    // inverted head and drive selects of whichever device the host addressed last
    assign devaddr = {2'h3, ~devhead_q[3:0], ~devhead_q[atd_pkg::DH_DRV_BIT], devhead_q[atd_pkg::DH_DRV_BIT]};

    always_comb begin
        rd_byte = atd_pkg::RST_BYTE;
        if (ctl_sel) begin
            // mirror byte is status as is, bsy at bit 7 down to err at bit 0
            rd_byte = (da_s == atd_pkg::ADR_MIRROR) ? core_status : devaddr;
        end else begin
            unique case (da_s)
                atd_pkg::ADR_DATA:     rd_byte = atd_pkg::RST_BYTE;
                atd_pkg::ADR_ERR_FEAT: rd_byte = core_error;
                atd_pkg::ADR_SECCNT:   rd_byte = seccnt_q;
                atd_pkg::ADR_SECNUM:   rd_byte = secnum_q;
                atd_pkg::ADR_CYLLO:    rd_byte = cyllo_q;
                atd_pkg::ADR_CYLHI:    rd_byte = cylhi_q;
                atd_pkg::ADR_DEVHEAD:  rd_byte = devhead_q;
                atd_pkg::ADR_STATCMD:  rd_byte = core_status;
            endcase
        end
        rd_word = (cmd_sel && (da_s == atd_pkg::ADR_DATA)) ? core_rd_data : {8'h00, rd_byte};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dd_out <= atd_pkg::RST_WORD;
            dd_oe_n <= 1'b1;
        end else if (ce) begin
            dd_out <= rd_word;
            dd_oe_n <= !rd_act;
        end
    end
endmodule
`default_nettype wire

/* File: atd_pkg.sv */
// atd_pkg: constants for the task file register decoder
// assumes: included before every design file of the decoder
package atd_pkg;

    // address codes on da[2:0]
    localparam logic [2:0] ADR_DATA     = 3'h0;
    localparam logic [2:0] ADR_ERR_FEAT = 3'h1;
    localparam logic [2:0] ADR_SECCNT   = 3'h2;
    localparam logic [2:0] ADR_SECNUM   = 3'h3;
    localparam logic [2:0] ADR_CYLLO    = 3'h4;
    localparam logic [2:0] ADR_CYLHI    = 3'h5;
    localparam logic [2:0] ADR_DEVHEAD  = 3'h6;
    localparam logic [2:0] ADR_STATCMD  = 3'h7;
    localparam logic [2:0] ADR_MIRROR   = 3'h6;
    localparam logic [2:0] ADR_DEVADDR  = 3'h7;

    // device control fields
    localparam int CTL_SRST_BIT = 2;
    localparam int CTL_NIEN_BIT = 1;

    // device/head fields
    localparam int DH_LBA_BIT = 6;
    localparam int DH_DRV_BIT = 4;

    // status fields, bit 7 down to 0
    localparam int ST_BSY  = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DF   = 5;
    localparam int ST_DSC  = 4;
    localparam int ST_DRQ  = 3;
    localparam int ST_CORR = 2;
    localparam int ST_IDX  = 1;
    localparam int ST_ERR  = 0;

    // values after reset
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  RST_DEVHEAD = 8'hA0;
    localparam logic [7:0]  RST_CTL     = 8'h08;
    localparam logic [15:0] RST_WORD    = 16'h0000;

    // check power mode answer in idle
    localparam logic [7:0] CPM_IDLE_VAL = 8'hFF;

    // strobe edge detect pipeline
    localparam int SYNC_STAGES = 2;

    // software reset hold time
    localparam int  SRST_HOLD_MS = 5;
    localparam int  CLK_HZ       = 125000000;
    localparam int  SRST_HOLD_CYC = (SRST_HOLD_MS * (CLK_HZ / 1000));

endpackage

/* File: atd_sync.sv */
// atd_sync: two flip-flop synchroniser for one pin
// assumes: clk free running, ce freezes it
`timescale 1ns/10ps
`default_nettype none
module atd_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and control
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // pin and result
    input  wire logic pin,
    output var  logic sync_q
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (ce) begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: atd_host_model.sv */
// atd_host_model: behavioural host controller driving the task file pins
// assumes: called from the bench; pins change only at falling clock edges
`timescale 1ns/10ps
`default_nettype none
module atd_host_model (
    // bus clock
    input  wire logic        clk,
    // host pins
    output var  logic        cs0_n,
    output var  logic        cs1_n,
    output var  logic [2:0]  da,
    output var  logic        dior_n,
    output var  logic        diow_n,
    output var  logic [15:0] dd_in,
    // device answer
    input  wire logic [15:0] dd_out,
    input  wire logic        dd_oe_n
);
    initial begin
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        da = 3'h0;
        dior_n = 1'b1;
        diow_n = 1'b1;
        dd_in = 16'h0000;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask
    // selects go high and address lines go to the inverse, so a stale value never looks valid
    task automatic drop(input logic [2:0] a);
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        da = ~a;
        gap(4);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic rd(input logic c0, input logic c1, input logic [2:0] a,
                      output logic [15:0] d, output logic oe_n);
        cs0_n = c0;
        cs1_n = c1;
        da = a;
        gap(3);
        dior_n = 1'b0;
        gap(8);
        d = dd_out;
        oe_n = dd_oe_n;
        dior_n = 1'b1;
        gap(8);
        drop(a);
    endtask
    task automatic wr(input logic c0, input logic c1, input logic [2:0] a, input logic [15:0] w);
        cs0_n = c0;
        cs1_n = c1;
        da = a;
        dd_in = w;
        gap(3);
        diow_n = 1'b0;
        gap(6);
        diow_n = 1'b1;
        gap(2);
        dd_in = ~w;
        gap(6);
        drop(a);
    endtask
endmodule
`default_nettype wire

/* File: atd_decoder_checker.sv */
// atd_decoder_checker: timing relations at the decoder ports
// assumes: one clock, ce held high, host keeps selects steady around strobes
`timescale 1ns/10ps
`default_nettype none
module atd_decoder_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // host pins
    input wire logic        cs0_n,
    input wire logic        cs1_n,
    input wire logic [2:0]  da,
    input wire logic        dior_n,
    input wire logic        diow_n,
    input wire logic [15:0] dd_out,
    input wire logic        dd_oe_n,
    input wire logic        intrq,
    // core side
    input wire logic [7:0]  core_status,
    input wire logic        core_irq_set,
    input wire logic        cmd_start,
    input wire logic        dev_srst
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // six cycles cover the two-flop sync plus the output register
    a_idle_bus_float: assert property ((cs0_n && cs1_n)[*6] |-> dd_oe_n)
        else $error("bus driven while unselected");
    a_both_sel_float: assert property ((!cs0_n && !cs1_n)[*6] |-> dd_oe_n)
        else $error("bus driven with both selects");
    a_ctl_hole_float: assert property ((cs0_n && !cs1_n && (!da[2] || da[2:1] == 2'h2))[*6] |-> dd_oe_n)
        else $error("bus driven on control hole");
    a_mirror_match: assert property ((cs0_n && !cs1_n && da == 3'h6 && $stable(core_status))[*8]
        ##0 !dd_oe_n |-> dd_out == {8'h00, core_status})
        else $error("mirrored status differs");
    a_mirror_keeps_irq: assert property (intrq && cs0_n && !cs1_n && !dior_n |=> intrq)
        else $error("mirror read dropped interrupt");
    a_status_clears_irq: assert property ((!cs0_n && cs1_n && da == 3'h7 && !dior_n && !core_irq_set)[*8]
        |-> !intrq)
        else $error("status read kept interrupt");
    a_cmd_start_seen: assert property ($rose(diow_n) && !cs0_n && cs1_n && da == 3'h7 && !dev_srst
        |-> ##[2:7] cmd_start)
        else $error("command write gave no start");
    a_no_cmd_in_srst: assert property (dev_srst[*8] |-> !cmd_start)
        else $error("command started during soft reset");
endmodule
bind atd_decoder atd_decoder_checker u_chk (.clk(clk), .sys_rst(sys_rst), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .da(da), .dior_n(dior_n), .diow_n(diow_n), .dd_out(dd_out), .dd_oe_n(dd_oe_n), .intrq(intrq),
    .core_status(core_status), .core_irq_set(core_irq_set), .cmd_start(cmd_start), .dev_srst(dev_srst));
`default_nettype wire

/* File: test_ata_task_file_decoder.sv */
// test_ata_task_file_decoder: directed bench for the task file decoder
// assumes: host model owns the pins, core side is driven here at falling edges
`timescale 1ns/10ps
`default_nettype none
module test_ata_task_file_decoder;
    typedef struct packed {
        logic [2:0] adr;
        logic [7:0] wv;
    } atd_row_t;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cs0_n, cs1_n, dior_n, diow_n, dd_oe_n, intrq, oe_v;
    logic        core_irq_set, core_cpm_done, core_idle, cmd_start, lba_mode, dev_srst;
    logic        data_wr, data_rd;
    logic [2:0]  da;
    logic [7:0]  core_status, core_error, cmd_code, features;
    logic [15:0] dd_in, dd_out, core_rd_data, data_wr_word, rd_v;
    logic [27:0] lba_addr;
    int          bad_count, total_checks, cyc;
    int          wr_pulses, rd_pulses;
    atd_row_t    rows [5] = '{'{3'h3, 8'h11}, '{3'h4, 8'h22}, '{3'h5, 8'h33}, '{3'h2, 8'h44}, '{3'h6, 8'hE5}};
    logic [4:0]  flt [5] = '{5'h03, 5'h12, 5'h14, 5'h15, 5'h1E};
    always #4 clk = ~clk;
    atd_host_model u_host (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .dior_n(dior_n),
        .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n));
    // ce tied high: freezing is not exercised here
    atd_decoder dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da),
        .dior_n(dior_n), .diow_n(diow_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
        .intrq(intrq), .core_status(core_status), .core_error(core_error), .core_irq_set(core_irq_set),
        .core_cpm_done(core_cpm_done), .core_idle(core_idle), .core_rd_data(core_rd_data),
        .cmd_code(cmd_code), .cmd_start(cmd_start), .features(features), .lba_addr(lba_addr),
        .lba_mode(lba_mode), .dev_srst(dev_srst), .data_wr(data_wr), .data_rd(data_rd),
        .data_wr_word(data_wr_word));
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic c0, input logic c1, input logic [2:0] a, input logic [15:0] e);
        u_host.rd(c0, c1, a, rd_v, oe_v);
        chk(oe_v, 1'b0);
        chk(rd_v, e);
    endtask
    task automatic pulse(input logic cpm);
        core_irq_set = ~cpm;
        core_cpm_done = cpm;
        @(negedge clk);
        core_irq_set = 1'b0;
        core_cpm_done = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (data_wr) begin
            wr_pulses <= wr_pulses + 1;
        end
        if (data_rd) begin
            rd_pulses <= rd_pulses + 1;
        end
        if (cyc == 30000) begin
            bad_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {core_irq_set, core_cpm_done, core_idle} = 3'h0;
        core_status = 8'h50;
        core_error = 8'h5C;
        core_rd_data = 16'hBEEF;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        chk(dd_oe_n, 1'b1);
        rdc(1'b0, 1'b1, atd_pkg::ADR_DEVHEAD, atd_pkg::RST_DEVHEAD);
        foreach (rows[i]) begin
            u_host.wr(1'b0, 1'b1, rows[i].adr, {8'h00, rows[i].wv});
            rdc(1'b0, 1'b1, rows[i].adr, {8'h00, rows[i].wv});
        end
        chk(lba_addr, 28'h5332211);
        chk(lba_mode, 1'b1);
        u_host.wr(1'b0, 1'b0, 3'h3, 16'h00FF);
        u_host.wr(1'b1, 1'b0, 3'h3, 16'h00FF);
        rdc(1'b0, 1'b1, 3'h3, 16'h0011);
        foreach (flt[i]) begin
            u_host.rd(flt[i][4], flt[i][3], flt[i][2:0], rd_v, oe_v);
            chk(oe_v, 1'b1);
        end
        rdc(1'b0, 1'b1, atd_pkg::ADR_ERR_FEAT, 16'h005C);
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_ERR_FEAT, 16'h00A5);
        chk(features, 8'hA5);
        rdc(1'b0, 1'b1, atd_pkg::ADR_DATA, 16'hBEEF);
        chk(rd_pulses[27:0], 28'h0000001);
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_DATA, 16'h1234);
        chk(data_wr_word, 16'h1234);
        chk(wr_pulses[27:0], 28'h0000001);
        rdc(1'b1, 1'b0, atd_pkg::ADR_DEVADDR, 16'h00EA);
        u_host.wr(1'b1, 1'b0, atd_pkg::ADR_DEVADDR, 16'h0004);
        chk(dev_srst, 1'b0);
        for (int i = 0; i < 8; i++) begin
            core_status = 8'h01 << i;
            rdc(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h0001 << i);
        end
        core_status = 8'hD9;
        pulse(1'b0);
        chk(intrq, 1'b1);
        rdc(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h00D9);
        chk(intrq, 1'b1);
        rdc(1'b0, 1'b1, atd_pkg::ADR_STATCMD, 16'h00D9);
        chk(intrq, 1'b0);
        u_host.wr(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h000A);
        pulse(1'b0);
        chk(intrq, 1'b0);
        u_host.wr(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h0008);
        rdc(1'b0, 1'b1, atd_pkg::ADR_STATCMD, 16'h00D9);
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_DEVHEAD, 16'h00F5);
        pulse(1'b0);
        chk(intrq, 1'b0);
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_DEVHEAD, 16'h00E5);
        chk(intrq, 1'b1);
        rdc(1'b0, 1'b1, atd_pkg::ADR_STATCMD, 16'h00D9);
        pulse(1'b1);
        rdc(1'b0, 1'b1, atd_pkg::ADR_SECCNT, 16'h0044);
        core_idle = 1'b1;
        pulse(1'b1);
        rdc(1'b0, 1'b1, atd_pkg::ADR_SECCNT, {8'h00, atd_pkg::CPM_IDLE_VAL});
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_STATCMD, 16'h00EC);
        chk(cmd_code, 8'hEC);
        u_host.wr(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h000C);
        chk(dev_srst, 1'b1);
        u_host.wr(1'b0, 1'b1, atd_pkg::ADR_STATCMD, 16'h0090);
        chk(cmd_code, 8'hEC);
        u_host.wr(1'b1, 1'b0, atd_pkg::ADR_MIRROR, 16'h0008);
        chk(dev_srst, 1'b0);
        sys_rst = 1'b1;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        rdc(1'b0, 1'b1, atd_pkg::ADR_DEVHEAD, atd_pkg::RST_DEVHEAD);
        chk(lba_addr, 28'h0000000);
        chk(lba_mode, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
